// File: rtl/bsc_status_bank.sv
// Pack status word and charge request registers with a word command port.
// Assumes an SMBus engine on link_clk that presents decoded word commands
// and that the gauge logic on core_clk supplies measurements and events.
//
// How it works
// R1 - Command 0x14 read returns requested charge current, 1 mA units.
// R2 - Zero current request tells the charger to switch its output off.
// R3 - Current request 65535 means run as constant voltage source.
// R4 - Command 0x15 returns requested charge voltage, 1 mV units.
// R5 - Voltage request 65535 means run as constant current source.
// R6 - Command 0x16 returns status: alarms high byte, conditions, error code.
// R7 - Over-charge alarm set on overcharge; cleared by discharge or idle timeout.
// R8 - Stop-charge alarm on bad charge parameter or termination; clears when over.
// R9 - Over-temperature alarm while temperature at or above its limit.
// R10 - Stop-discharge alarm when voltage below final threshold or cell undervoltage.
// R11 - Capacity alarm while remaining capacity below the host alarm level.
// R12 - Runtime alarm while runtime left below host level; follows capacity mode.
// R13 - Config valid flag set on good load, cleared on bad load.
// R14 - Not-charging flag follows absence of detected charging.
// R15 - Full flag set on termination or overcharge, cleared at low charge percent.
// R16 - Empty flag set below second threshold, cleared at 20 percent or more.
// R17 - Error code 0 after clean command, 7 for unidentified fault.
// R18 - Error code 1 when busy, 5 on data overflow or underflow.
// R19 - Error code 2 for reserved command, 3 for defined but unimplemented.
// R20 - Error code 4 for a write to a read-only command.
// R21 - Error code 6 for a write carrying a wrongly sized block.
// R22 - Broadcast message is the status word with error bits all high.
// R23 - Capacity mode selects mAh or 10 mWh values for the alarm compares.
// R24 - Reserved status bits always read zero.

`timescale 1ns/10ps
`default_nettype none

module bsc_status_bank #(
	parameter int unsigned TICK_CYCLES = bsc_pkg::CLK_HZ * bsc_pkg::TICK_S
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        link_clk,
	input  wire logic        link_rst_n,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [7:0]  req_cmd,
	input  wire logic [5:0]  req_len,
	output var  logic        link_ready,
	output var  logic        rsp_valid,
	output var  logic [15:0] rsp_data,
	input  wire logic [15:0] charge_current_in,
	input  wire logic [15:0] charge_voltage_in,
	input  wire logic        overcharge_seen,
	input  wire logic        chg_param_bad,
	input  wire logic        primary_term,
	input  wire logic        charging_active,
	input  wire logic        pack_not_charging_active,
	input  wire logic [15:0] pack_voltage,
	input  wire logic [15:0] final_empty_threshold,
	input  wire logic [15:0] second_empty_threshold,
	input  wire logic [15:0] pack_temp,
	input  wire logic [15:0] temperature_limit,
	input  wire logic        cell_undervoltage_flag,
	input  wire logic        capacity_mode,
	input  wire logic [15:0] remcap_mah,
	input  wire logic [15:0] remcap_cwh,
	input  wire logic [15:0] capacity_alarm_level,
	input  wire logic [15:0] runtime_left_mah,
	input  wire logic [15:0] runtime_left_cwh,
	input  wire logic [15:0] runtime_alarm_level,
	input  wire logic [6:0]  charge_percent,
	input  wire logic [6:0]  full_clear_percent,
	input  wire logic        config_load_ok,
	input  wire logic        config_load_bad,
	input  wire logic [7:0]  filter_setting,
	input  wire logic        gauge_busy,
	input  wire logic        data_overflow,
	input  wire logic        unknown_fault,
	output var  logic [15:0] charge_current_request,
	output var  logic [15:0] charge_voltage_request,
	output var  logic [15:0] pack_status_word,
	output var  logic [15:0] alarm_broadcast_message,
	output var  logic        alarm_broadcast_valid
);

	// ------------------------------------------------
	// Link side: hold request until core answers
	// ------------------------------------------------
	logic        pend_reg;
	logic        req_tgl_reg;
	logic        lnk_write_reg;
	logic [7:0]  lnk_cmd_reg;
	logic [5:0]  lnk_len_reg;
	logic        ack_s1_reg;
	logic        ack_s2_reg;
	logic        ack_s3_reg;
	logic [15:0] rsp_hold_reg;
	logic        ack_tgl_reg;
	logic        ack_seen;

	assign ack_seen = ack_s2_reg ^ ack_s3_reg;

	// Requests made while one is pending are dropped; link_ready shows it
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			pend_reg      <= 1'b0;
			req_tgl_reg   <= 1'b0;
			lnk_write_reg <= 1'b0;
			lnk_cmd_reg   <= 8'h00;
			lnk_len_reg   <= 6'h00;
		end else if (req_valid && !pend_reg) begin
			pend_reg      <= 1'b1;
			req_tgl_reg   <= ~req_tgl_reg;
			lnk_write_reg <= req_write;
			lnk_cmd_reg   <= req_cmd;
			lnk_len_reg   <= req_len;
		end else if (ack_seen) begin
			pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_s3_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
		end
	end

	// Answer word is stable in the core before the toggle arrives here
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			rsp_valid  <= 1'b0;
			rsp_data   <= 16'h0000;
			link_ready <= 1'b0;
		end else begin
			rsp_valid  <= ack_seen;
			link_ready <= !(pend_reg || (req_valid && !pend_reg)) || ack_seen;
			if (ack_seen) begin
				rsp_data <= rsp_hold_reg;
			end
		end
	end

	// ------------------------------------------------
	// Core side: request crossing and decode
	// ------------------------------------------------
	logic        req_s1_reg;
	logic        req_s2_reg;
	logic        req_s3_reg;
	logic        req_seen;
	logic [15:0] rd_data;
	logic [2:0]  cmd_err;
	logic        is_bank;

	assign req_seen = req_s2_reg ^ req_s3_reg;
	assign is_bank  = (lnk_cmd_reg >= bsc_pkg::CMD_CURRENT) &&
		(lnk_cmd_reg <= bsc_pkg::CMD_STATUS);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	always_comb begin
		rd_data = 16'h0000;
		cmd_err = bsc_pkg::ERR_OK;                                        // R17
		if (gauge_busy) begin
			cmd_err = bsc_pkg::ERR_BUSY;                                  // R18
		end else if (lnk_write_reg && lnk_len_reg != bsc_pkg::WORD_LEN) begin
			cmd_err = bsc_pkg::ERR_BLOCK_LENGTH_ERROR;                               // R21
		end else if (is_bank) begin
			if (lnk_write_reg) begin
				cmd_err = bsc_pkg::ERR_READONLY;                          // R20
			end else begin
				case (lnk_cmd_reg)
					bsc_pkg::CMD_CURRENT: rd_data = charge_current_request; // R1
					bsc_pkg::CMD_VOLTAGE: rd_data = charge_voltage_request; // R4
					default:              rd_data = pack_status_word;       // R6
				endcase
			end
		end else if (lnk_cmd_reg <= bsc_pkg::CMD_DEF_LAST ||
			(lnk_cmd_reg >= bsc_pkg::CMD_BLK_FIRST &&
			lnk_cmd_reg <= bsc_pkg::CMD_BLK_LAST)) begin
			cmd_err = bsc_pkg::ERR_UNSUPP;                                // R19
		end else begin
			cmd_err = bsc_pkg::ERR_RESERVED;                              // R19
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rsp_hold_reg <= 16'h0000;
			ack_tgl_reg  <= 1'b0;
		end else if (req_seen) begin
			rsp_hold_reg <= rd_data;
			ack_tgl_reg  <= ~ack_tgl_reg;
		end
	end

	// A failing command wins, then a fault event, then a clean command
	logic [2:0] err_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			err_reg <= bsc_pkg::ERR_OK;
		end else if (req_seen && cmd_err != bsc_pkg::ERR_OK) begin
			err_reg <= cmd_err;
		end else if (unknown_fault) begin
			err_reg <= bsc_pkg::ERR_UNKNOWN;                              // R17
		end else if (data_overflow) begin
			err_reg <= bsc_pkg::ERR_OVERFLOW;                             // R18
		end else if (req_seen) begin
			err_reg <= bsc_pkg::ERR_OK;                                   // R17
		end
	end

	// ------------------------------------------------
	// Charge requests
	// ------------------------------------------------
	// Zero and all-ones are passed through untouched: the charger acts on them
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			charge_current_request <= 16'h0000;
			charge_voltage_request <= 16'h0000;
		end else begin
			charge_current_request <= charge_current_in;                  // R2 R3
			charge_voltage_request <= charge_voltage_in;                  // R5
		end
	end

	// ------------------------------------------------
	// Idle timeout for the over-charge alarm
	// ------------------------------------------------
	logic [31:0] sec_cnt_reg;
	logic        sec_tick;
	logic [11:0] idle_secs_reg;
	logic [11:0] idle_limit;
	logic        pack_idle;
	logic        idle_timeout;

	assign sec_tick     = sec_cnt_reg == 32'(TICK_CYCLES - 1);
	assign pack_idle    = !charging_active && !pack_not_charging_active;
	assign idle_limit   = {4'h0, filter_setting} * bsc_pkg::TIMEOUT_MULT;
	assign idle_timeout = pack_idle && idle_secs_reg >= idle_limit;  // R7

	always_ff @(posedge core_clk) begin
		if (!rst_n || sec_tick) begin
			sec_cnt_reg <= 32'h0000_0000;
		end else begin
			sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
		end
	end

	// Saturates so a long idle spell never wraps back under the limit
	always_ff @(posedge core_clk) begin
		if (!rst_n || !pack_idle) begin
			idle_secs_reg <= 12'h000;
		end else if (sec_tick && idle_secs_reg != 12'hfff) begin
			idle_secs_reg <= idle_secs_reg + 12'h001;
		end
	end

	// ------------------------------------------------
	// Status flags
	// ------------------------------------------------
	logic        over_chg_reg;
	logic        stop_charge_flag;
	logic        chg_cond_reg;
	logic        chg_cond;
	logic        charging_d_reg;
	logic        cfg_valid_reg;
	logic        full_reg;
	logic        empty_reg;
	logic [15:0] cap_now;
	logic [15:0] run_now;
	logic [15:0] stat_next;

	assign chg_cond = chg_param_bad || primary_term;
	assign cap_now  = capacity_mode ? remcap_cwh : remcap_mah;              // R23
	assign run_now  = capacity_mode ? runtime_left_cwh : runtime_left_mah;  // R12

	// Hardware set beats every clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			over_chg_reg <= 1'b0;
		end else if (overcharge_seen) begin
			over_chg_reg <= 1'b1;                                         // R7
		end else if (pack_not_charging_active || idle_timeout) begin
			over_chg_reg <= 1'b0;                                         // R7
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stop_charge_flag <= 1'b0;
			chg_cond_reg     <= 1'b0;
			charging_d_reg   <= 1'b0;
		end else begin
			chg_cond_reg   <= chg_cond;
			charging_d_reg <= charging_active;
			if (chg_cond && !chg_cond_reg) begin
				stop_charge_flag <= 1'b1;                                 // R8
			end else if (!chg_cond || (charging_d_reg && !charging_active)) begin
				stop_charge_flag <= 1'b0;                                 // R8
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_valid_reg <= 1'b0;
		end else if (config_load_ok) begin
			cfg_valid_reg <= 1'b1;                                        // R13
		end else if (config_load_bad) begin
			cfg_valid_reg <= 1'b0;                                        // R13
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			full_reg <= 1'b0;
		end else if (primary_term || overcharge_seen) begin
			full_reg <= 1'b1;                                             // R15
		end else if (charge_percent <= full_clear_percent) begin
			full_reg <= 1'b0;                                             // R15
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			empty_reg <= 1'b0;
		end else if (pack_voltage < second_empty_threshold) begin
			empty_reg <= 1'b1;                                            // R16
		end else if (charge_percent >= bsc_pkg::EMPTY_CLEAR_PCT) begin
			empty_reg <= 1'b0;                                            // R16
		end
	end

	// Reserved positions stay zero from the default below
	always_comb begin
		stat_next = 16'h0000;                                             // R24
		stat_next[bsc_pkg::BIT_OVER_CHARGE] = over_chg_reg;
		stat_next[bsc_pkg::BIT_STOP_CHARGE] = stop_charge_flag;
		stat_next[bsc_pkg::BIT_OVER_TEMP]   = pack_temp >= temperature_limit;  // R9
		stat_next[bsc_pkg::BIT_STOP_DISCH]  =
			pack_voltage < final_empty_threshold || cell_undervoltage_flag;    // R10
		stat_next[bsc_pkg::BIT_CAP_ALARM]   = cap_now < capacity_alarm_level;  // R11
		stat_next[bsc_pkg::BIT_TIME_ALARM]  = run_now < runtime_alarm_level;   // R12
		stat_next[bsc_pkg::BIT_CFG_VALID]   = cfg_valid_reg;
		stat_next[bsc_pkg::BIT_NOT_CHARGE]  = !charging_active;                // R14
		stat_next[bsc_pkg::BIT_FULL]        = full_reg;
		stat_next[bsc_pkg::BIT_EMPTY]       = empty_reg;
		stat_next[2:0]                      = err_reg;                         // R6
	end

	// ------------------------------------------------
	// Status word and alarm broadcast
	// ------------------------------------------------
	logic alarm_rise;

	assign alarm_rise = |(stat_next[bsc_pkg::ALARM_MSB:bsc_pkg::ALARM_LSB] &
		~pack_status_word[bsc_pkg::ALARM_MSB:bsc_pkg::ALARM_LSB]);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pack_status_word <= bsc_pkg::STATUS_RESET;
		end else begin
			pack_status_word <= stat_next;                                // R6
		end
	end

	// Sent only when a new alarm appears, so a standing alarm is not repeated
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			alarm_broadcast_message <= bsc_pkg::STATUS_RESET;
			alarm_broadcast_valid   <= 1'b0;
		end else begin
			alarm_broadcast_valid <= alarm_rise;
			if (alarm_rise) begin
				alarm_broadcast_message <= {stat_next[15:3], bsc_pkg::ERR_UNKNOWN}; // R22
			end
		end
	end

endmodule : bsc_status_bank

`default_nettype wire

// File: rtl/bsc_pkg.sv
// Constants for the pack status and charge request register block.
// Assumes a 50 MHz core clock; link side decodes SMBus word transfers.

package bsc_pkg;

	// ------------------------------------------------
	// Command codes
	// ------------------------------------------------
	localparam logic [7:0] CMD_CURRENT   = 8'h14;
	localparam logic [7:0] CMD_VOLTAGE   = 8'h15;
	localparam logic [7:0] CMD_STATUS    = 8'h16;
	localparam logic [7:0] CMD_DEF_LAST  = 8'h1c;
	localparam logic [7:0] CMD_BLK_FIRST = 8'h20;
	localparam logic [7:0] CMD_BLK_LAST  = 8'h23;
	localparam logic [5:0] WORD_LEN      = 6'h02;

	// ------------------------------------------------
	// Status word bit positions
	// ------------------------------------------------
	localparam int BIT_OVER_CHARGE = 15;
	localparam int BIT_STOP_CHARGE = 14;
	localparam int BIT_OVER_TEMP   = 12;
	localparam int BIT_STOP_DISCH  = 11;
	localparam int BIT_CAP_ALARM   = 9;
	localparam int BIT_TIME_ALARM  = 8;
	localparam int BIT_CFG_VALID   = 7;
	localparam int BIT_NOT_CHARGE  = 6;
	localparam int BIT_FULL        = 5;
	localparam int BIT_EMPTY       = 4;
	localparam int ALARM_MSB       = 15;
	localparam int ALARM_LSB       = 8;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// ------------------------------------------------
	// Error codes
	// ------------------------------------------------
	localparam logic [2:0] ERR_OK       = 3'h0;
	localparam logic [2:0] ERR_BUSY     = 3'h1;
	localparam logic [2:0] ERR_RESERVED = 3'h2;
	localparam logic [2:0] ERR_UNSUPP   = 3'h3;
	localparam logic [2:0] ERR_READONLY = 3'h4;
	localparam logic [2:0] ERR_OVERFLOW = 3'h5;
	localparam logic [2:0] ERR_BLOCK_LENGTH_ERROR  = 3'h6;
	localparam logic [2:0] ERR_UNKNOWN  = 3'h7;

	// ------------------------------------------------
	// Thresholds and timing
	// ------------------------------------------------
	localparam logic [6:0]  EMPTY_CLEAR_PCT = 7'h14;
	localparam logic [11:0] TIMEOUT_MULT    = 12'h00a;
	localparam int          CLK_HZ          = 32'h02fa_f080;
	localparam int          TICK_S          = 1;

endpackage : bsc_pkg

// File: verification/bsc_status_bank_chk.sv
// Checker for the status bank: request lag, flag compares, broadcast word.
// Assumes it is bound into bsc_status_bank and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module bsc_status_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [15:0] charge_current_in,
	input wire logic [15:0] charge_voltage_in,
	input wire logic [15:0] charge_current_request,
	input wire logic [15:0] charge_voltage_request,
	input wire logic [15:0] pack_status_word,
	input wire logic [15:0] pack_temp,
	input wire logic [15:0] temperature_limit,
	input wire logic [15:0] pack_voltage,
	input wire logic [15:0] final_empty_threshold,
	input wire logic [15:0] second_empty_threshold,
	input wire logic        cell_undervoltage_flag,
	input wire logic        capacity_mode,
	input wire logic [15:0] remcap_mah,
	input wire logic [15:0] remcap_cwh,
	input wire logic [15:0] capacity_alarm_level,
	input wire logic        charging_active,
	input wire logic        alarm_broadcast_valid,
	input wire logic [15:0] alarm_broadcast_message
);
	// ----------------------------------------
	// Core domain properties
	// ----------------------------------------
	// Repetition counts give margin for the two-cycle lag of sticky bits
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_REQ_LAG: assert property ($past(rst_n) |->
		{charge_current_request, charge_voltage_request} ==
		$past({charge_current_in, charge_voltage_in})) else $error("request lag wrong");
	AST_RSVD_ZERO: assert property ((pack_status_word & 16'h2408) == 16'h0000)
		else $error("reserved status bit set");
	AST_TEMP_SET: assert property ((pack_temp >= temperature_limit)[*3] |->
		pack_status_word[12]) else $error("over-temperature not set");
	AST_TEMP_CLR: assert property ((pack_temp < temperature_limit)[*3] |->
		!pack_status_word[12]) else $error("over-temperature not cleared");
	AST_DISCH_SET: assert property ((pack_voltage < final_empty_threshold ||
		cell_undervoltage_flag)[*3] |-> pack_status_word[11]) else $error("stop-discharge");
	AST_CAP_SET: assert property (((capacity_mode ? remcap_cwh : remcap_mah) <
		capacity_alarm_level)[*3] |-> pack_status_word[9]) else $error("capacity alarm");
	AST_EMPTY_SET: assert property ((pack_voltage < second_empty_threshold)[*4] |->
		pack_status_word[4]) else $error("empty flag not set");
	AST_NOT_CHG: assert property ((!charging_active)[*3] |-> pack_status_word[6])
		else $error("not-charging flag not set");
	AST_BC_WORD: assert property (alarm_broadcast_valid |->
		alarm_broadcast_message == {pack_status_word[15:3], 3'h7}) else $error("broadcast word");
	AST_BC_CAUSE: assert property (alarm_broadcast_valid |->
		(pack_status_word[15:8] & ~$past(pack_status_word[15:8])) != 8'h00)
		else $error("broadcast without new alarm");
endmodule : bsc_status_chk
bind bsc_status_bank bsc_status_chk i_bsc_status_chk (.*);
`default_nettype wire

// File: verification/bsc_host_model.sv
// Host and charger model on the link command port.
// Assumes the bench calls xfer and checks the answers itself.
`timescale 1ns/10ps
`default_nettype none
module bsc_host_model (
	input  wire logic        link_clk,
	input  wire logic        link_ready,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data,
	output var  logic        req_valid,
	output var  logic        req_write,
	output var  logic [7:0]  req_cmd,
	output var  logic [5:0]  req_len
);
	logic chg_out_on;
	logic cv_mode;
	logic cc_mode;
	initial begin
		{req_valid, req_write, req_cmd, req_len} = 16'h0000;
	end
	// ----------------------------------------
	// One command, held until taken
	// ----------------------------------------
	task xfer(input logic w, input logic [7:0] c, input logic [5:0] l, output logic ok);
		int k;
		ok = 1'b0;
		@(posedge link_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_cmd <= c;
		req_len <= l;
		for (k = 0; k < 50; k++) begin
			@(posedge link_clk);
			if (link_ready) break;
		end
		// Released lines show the inverse so stale values are not mistaken
		req_valid <= 1'b0;
		req_write <= ~w;
		req_cmd <= ~c;
		req_len <= ~l;
		for (k = 0; k < 100; k++) begin
			@(posedge link_clk);
			if (rsp_valid) begin
				ok = 1'b1;
				break;
			end
		end
		if (ok && !w && c == bsc_pkg::CMD_CURRENT) begin
			chg_out_on = (rsp_data != 16'h0000);
			cv_mode = (rsp_data == 16'hffff);
		end
		if (ok && !w && c == bsc_pkg::CMD_VOLTAGE) begin
			cc_mode = (rsp_data == 16'hffff);
		end
	endtask : xfer
endmodule : bsc_host_model
`default_nettype wire

// File: verification/bsc_status_bank_tb.sv
// Self-checking bench for the pack status and charge request block.
// Assumes the host model on the link port and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module bsc_status_bank_tb;
	logic        core_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst_n, link_rst_n, req_valid, req_write, link_ready, rsp_valid;
	logic        chg_param_bad, primary_term, charging_active, pack_not_charging_active;
	logic        cell_undervoltage_flag, capacity_mode, gauge_busy, alarm_broadcast_valid;
	logic        overcharge_seen, config_load_ok, config_load_bad, data_overflow, unknown_fault;
	logic [4:0]  pv;
	logic [5:0]  req_len;
	logic [6:0]  charge_percent, full_clear_percent;
	logic [7:0]  req_cmd, filter_setting;
	logic [15:0] rsp_data, charge_current_in, charge_voltage_in, pack_voltage, pack_temp, v;
	logic [15:0] final_empty_threshold, second_empty_threshold, temperature_limit;
	logic [15:0] remcap_mah, remcap_cwh, capacity_alarm_level, runtime_left_mah;
	logic [15:0] runtime_left_cwh, runtime_alarm_level, charge_current_request;
	logic [15:0] charge_voltage_request, pack_status_word, alarm_broadcast_message;
	logic [31:0] expq[$];
	logic [31:0] eq;
	logic [15:0] bc_seen;
	logic [18:0] tbl[10];
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          i;
	assign {overcharge_seen, config_load_ok, config_load_bad, data_overflow, unknown_fault} = pv;
	// Short tick keeps the idle timeout at 100 core cycles per filter unit
	bsc_status_bank #(.TICK_CYCLES(10)) i_bsc_status_bank (.*);
	bsc_host_model i_bsc_host_model (.*);
	initial forever #10 core_clk = ~core_clk;
	initial begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	// ----------------------------------------
	// Checks and helpers
	// ----------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	task guard(input logic ok);
		if (!ok) begin
			chk(16'h0000, 16'h0001);
			conclude();
		end
	endtask : guard
	task look(input logic [15:0] m, input logic [15:0] x);
		repeat (4) @(negedge core_clk);
		chk(pack_status_word & m, x);
	endtask : look
	task pulse(input logic [4:0] m);
		@(negedge core_clk);
		pv = m;
		@(negedge core_clk);
		pv = 5'h00;
	endtask : pulse
	// Entry: busy, write, command, length, expected error code
	task link_pair(input logic [18:0] t);
		logic ok;
		@(negedge core_clk);
		gauge_busy = t[18];
		v = (t[16:9] == bsc_pkg::CMD_CURRENT) ? charge_current_in : charge_voltage_in;
		expq.push_back({16'hffff, (t[2:0] != 3'h0) ? 16'h0000 : v});
		i_bsc_host_model.xfer(t[17], t[16:9], t[8:3], ok);
		guard(ok);
		@(negedge core_clk);
		gauge_busy = 1'b0;
		expq.push_back({16'h0007, 13'h0000, t[2:0]});
		i_bsc_host_model.xfer(1'b0, bsc_pkg::CMD_STATUS, 6'h02, ok);
		guard(ok);
	endtask : link_pair
	// Keeps the last broadcast word so a test can compare it after the pulse
	always @(posedge core_clk) begin
		if (alarm_broadcast_valid === 1'b1) begin
			bc_seen <= alarm_broadcast_message;
		end
	end
	always @(posedge link_clk) begin
		if (rsp_valid === 1'b1) begin
			eq = expq.pop_front();
			chk(rsp_data & eq[31:16], eq[15:0]);
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h9442cae0));
		{rst_n, link_rst_n, pv} = 7'h00;
		{chg_param_bad, primary_term, pack_not_charging_active, cell_undervoltage_flag} = 4'h0;
		{capacity_mode, gauge_busy, charging_active} = 3'h1;
		{charge_current_in, charge_voltage_in, pack_voltage, pack_temp} = 64'h0000_0000_4000_0100;
		{final_empty_threshold, second_empty_threshold, temperature_limit} = 48'h1000_2000_0200;
		{remcap_mah, remcap_cwh, capacity_alarm_level} = 48'h8000_8000_0100;
		{runtime_left_mah, runtime_left_cwh, runtime_alarm_level} = 48'h8000_8000_0100;
		{charge_percent, full_clear_percent, filter_setting} = {7'h32, 7'h0a, 8'h01};
		tbl = '{{2'h0, 8'h14, 6'h02, 3'h0}, {2'h1, 8'h14, 6'h02, 3'h4}, {2'h1, 8'h15, 6'h03, 3'h6},
			{2'h0, 8'h17, 6'h02, 3'h3}, {2'h0, 8'h1c, 6'h02, 3'h3}, {2'h0, 8'h1d, 6'h02, 3'h2},
			{2'h0, 8'h23, 6'h02, 3'h3}, {2'h1, 8'h16, 6'h02, 3'h4}, {2'h2, 8'h15, 6'h02, 3'h1},
			{2'h0, 8'h15, 6'h02, 3'h0}};
		repeat (10) @(negedge core_clk);
		{rst_n, link_rst_n} = 2'h3;
		for (i = 0; i < 6; i++) begin
			@(negedge core_clk);
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
			charge_current_in = v;
			charge_voltage_in = ~v;
			@(negedge core_clk);
			chk(charge_current_request, v);
			chk(charge_voltage_request, ~v);
		end
		$display("test requests done");
		charge_voltage_in = 16'hffff;
		for (i = 0; i < 10; i++) begin
			link_pair(tbl[i]);
		end
		link_pair({2'h0, 8'(8'h24 + $urandom_range(219)), 6'h02, 3'h2});
		chk(16'({i_bsc_host_model.chg_out_on, i_bsc_host_model.cv_mode,
			i_bsc_host_model.cc_mode}), 16'({|charge_current_in, &charge_current_in, 1'b1}));
		pulse(5'h02);
		look(16'h0007, 16'h0005);
		pulse(5'h03);
		look(16'h0007, 16'h0007);
		$display("test link done");
		pack_temp = 16'h0200;
		look(16'h1000, 16'h1000);
		chk(bc_seen, 16'h1007);
		pack_temp = 16'h01ff;
		look(16'h1000, 16'h0000);
		cell_undervoltage_flag = 1'b1;
		look(16'h0800, 16'h0800);
		cell_undervoltage_flag = 1'b0;
		pack_voltage = 16'h0fff;
		look(16'h0800, 16'h0800);
		pack_voltage = 16'h4000;
		look(16'h2c08, 16'h0000);
		remcap_mah = 16'h00ff;
		look(16'h0200, 16'h0200);
		capacity_mode = 1'b1;
		look(16'h0200, 16'h0000);
		runtime_left_cwh = 16'h0000;
		look(16'h0100, 16'h0100);
		runtime_alarm_level = 16'h0000;
		look(16'h0100, 16'h0000);
		charging_active = 1'b0;
		look(16'h0040, 16'h0040);
		charging_active = 1'b1;
		look(16'h0040, 16'h0000);
		chg_param_bad = 1'b1;
		look(16'h4000, 16'h4000);
		chg_param_bad = 1'b0;
		look(16'h4000, 16'h0000);
		primary_term = 1'b1;
		look(16'h4020, 16'h4020);
		primary_term = 1'b0;
		look(16'h4020, 16'h0020);
		charge_percent = 7'h0a;
		look(16'h0020, 16'h0000);
		charge_percent = 7'h13;
		pack_voltage = 16'h1fff;
		look(16'h0010, 16'h0010);
		pack_voltage = 16'h4000;
		look(16'h0010, 16'h0010);
		charge_percent = 7'h14;
		look(16'h0010, 16'h0000);
		pulse(5'h08);
		look(16'h0080, 16'h0080);
		pulse(5'h04);
		look(16'h0080, 16'h0000);
		pulse(5'h10);
		look(16'h8000, 16'h8000);
		pack_not_charging_active = 1'b1;
		look(16'h8000, 16'h0000);
		pack_not_charging_active = 1'b0;
		pulse(5'h10);
		charging_active = 1'b0;
		repeat (76) @(negedge core_clk);
		look(16'h8000, 16'h8000);
		repeat (60) @(negedge core_clk);
		look(16'h8000, 16'h0000);
		$display("test flags done");
		conclude();
	end
endmodule : bsc_status_bank_tb
`default_nettype wire
